/* File: inc/ccu_defines.svh */
// Offsets, bit positions, reset values and counts of the clock select unit.
// Assumes an 8-bit register port with byte offsets as listed here.
`ifndef CCU_DEFINES_SVH
`define CCU_DEFINES_SVH
`define CCU_OFS_CLKS     8'h39
`define CCU_OFS_PLL      8'h3A
`define CCU_BIT_PLLSRC   7
`define CCU_BIT_PSTOP    6
`define CCU_BIT_TICKRUN  3
`define CCU_BIT_WDRUN    2
`define CCU_BIT_TICKSRC  1
`define CCU_BIT_WDSRC    0
`define CCU_FM_HI        5
`define CCU_FM_LO        4
`define CCU_CLKS_RESET   8'h80
`define CCU_PLL_RESET    8'h00
`define CCU_NORMAL_MASK  8'hCE
`define CCU_SPECIAL_MASK 8'hCF
`define CCU_FM_RATE_DIV  16
`define CCU_LOCKED_DIV   4
`endif

/* File: inc/ccu_pkg.sv */
// Types of the clock select unit.
// Assumes ccu_defines.svh for all numeric constants.
package ccu_pkg;
   // Clock select register image, bit 7 down to bit 0
   typedef struct packed {
      logic       system_clock_from_pll;
      logic       pseudo_stop_select;
      logic [1:0] reserved;
      logic       tick_run_in_stop;
      logic       watchdog_run_in_stop;
      logic       tick_clock_source;
      logic       watchdog_clock_source;
   } ccu_clks_t;

   // Run control for the two timers while stop is active
   typedef struct packed {
      logic tick_freeze;
      logic watchdog_freeze;
   } ccu_freeze_t;

   // Frequency modulation amplitude codes
   typedef enum logic [1:0] {
      CCU_FM_OFF = 2'h0,
      CCU_FM_1PC = 2'h1,
      CCU_FM_2PC = 2'h2,
      CCU_FM_4PC = 2'h3
   } ccu_fm_t;
endpackage : ccu_pkg

/* File: rtl/ccu_clock_ctrl.sv */
// Clock source select and PLL modulation control registers.
// Assumes synchronous inputs from the protection logic, mode straps,
// oscillator and PLL monitors, and a plain 8-bit register port.
//
// The strobed register port was chosen for this implementation.
`timescale 1ns/100ps
`include "ccu_defines.svh"
module ccu_clock_ctrl
   import ccu_pkg::*;
#(
   parameter int FM_RATE_DIV = `CCU_FM_RATE_DIV
) (
   input  wire logic       sys_clk,
   input  wire logic       rstn,
   input  wire logic [7:0] reg_addr,
   input  wire logic [7:0] reg_wdata,
   input  wire logic       reg_wr,
   input  wire logic       reg_rd,
   output      logic [7:0] reg_rdata,
   input  wire logic       write_protect_flag,
   input  wire logic       special_mode,
   input  wire logic       watchdog_ctrl_write,
   input  wire logic       stop_entry,
   input  wire logic       stop_active,
   input  wire logic       osc_qualified_in,
   input  wire logic       pll_locked_in,
   output      ccu_clks_t  clock_source_select,
   output      ccu_freeze_t timer_freeze,
   output      logic       tick_restart,
   output      logic       watchdog_restart,
   output      logic       osc_qualified,
   output      logic       pll_locked,
   output      logic       pll_status_clear,
   output      logic       osc_status_clear,
   output      logic       pll_div4,
   output      ccu_fm_t    freq_mod_amp,
   output      logic [2:0] freq_mod_pct,
   output      logic       freq_mod_step
);

   // Divider must hold at least two states to make a pulse
   if (FM_RATE_DIV < 2 || FM_RATE_DIV > 256) begin : g_chk
      $error("FM_RATE_DIV out of range");
   end

   localparam logic [7:0] FM_LAST = 8'(FM_RATE_DIV - 1);

   ccu_clks_t  clks_q;
   ccu_clks_t  clks_d;
   ccu_fm_t    fm_q;
   logic       wr_clks;
   logic       wr_pll;
   logic       full_stop_entry;
   logic [7:0] wmask;
   logic       wd_locked_q;
   logic       wd_rearm_q;
   logic       wd_src_ok;
   logic [1:0] st_in;
   logic [1:0] st_clr;
   logic [1:0] st_prev_q;
   logic [1:0] st_q;
   logic [7:0] fm_cnt_q;

   // Write qualification for both registers
   assign wr_clks = reg_wr && reg_addr == `CCU_OFS_CLKS
                    && !write_protect_flag;
   assign wr_pll  = reg_wr && reg_addr == `CCU_OFS_PLL
                    && !write_protect_flag
                    && clks_q.system_clock_from_pll;
   assign full_stop_entry = stop_entry && !clks_q.pseudo_stop_select;

   // Watchdog source stays open in normal mode until the watchdog is set up
   assign wd_src_ok = special_mode || !wd_locked_q || wd_rearm_q;
   assign wmask = special_mode ? `CCU_SPECIAL_MASK
                  : (`CCU_NORMAL_MASK | {7'h00, wd_src_ok});

   // Next clock select value; hardware forcing is applied last so it wins
   always_comb begin
      clks_d = clks_q;
      if (wr_clks) begin
         clks_d = ccu_clks_t'((clks_q & ~wmask) | (reg_wdata & wmask));
         clks_d.reserved = 2'h0;
         if (!st_q[0]) begin
            clks_d.system_clock_from_pll = 1'b1;
            clks_d.tick_clock_source = clks_q.tick_clock_source;
            clks_d.watchdog_clock_source = clks_q.watchdog_clock_source;
         end
      end
      if (!st_q[0]) begin
         clks_d.system_clock_from_pll = 1'b1;
         clks_d.tick_clock_source = 1'b0;
         clks_d.watchdog_clock_source = 1'b0;
      end
      if (full_stop_entry) begin
         clks_d.system_clock_from_pll = 1'b1;
      end
   end

   // Clock select register; bit 7 steers the system and bus clock source
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         clks_q <= ccu_clks_t'(`CCU_CLKS_RESET);
      end else begin
         clks_q <= clks_d;
      end
   end

   // Watchdog source lock: closed by the first watchdog setup in normal mode
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         wd_locked_q <= 1'b0;
      end else if (watchdog_ctrl_write && !special_mode) begin
         wd_locked_q <= 1'b1;
      end
   end

   // One more set is allowed after loss of qualification cleared the bit;
   // the loss event wins over the consuming write
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         wd_rearm_q <= 1'b0;
      end else if (!st_q[0] && clks_q.watchdog_clock_source) begin
         wd_rearm_q <= 1'b1;
      end else if (wr_clks && !special_mode && wd_locked_q
                   && clks_d.watchdog_clock_source) begin
         wd_rearm_q <= 1'b0;
      end
   end

   // Modulation register; only the two amplitude bits exist
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         fm_q <= ccu_fm_t'(2'(`CCU_PLL_RESET >> `CCU_FM_LO));
      end else if (wr_pll) begin
         fm_q <= ccu_fm_t'(reg_wdata[`CCU_FM_HI:`CCU_FM_LO]);
      end
   end

   // Status channels: 0 is oscillator qualification, 1 is PLL lock.
   // A clear holds the status low until the monitor reports a fresh rise,
   // so a monitor that is slow to drop cannot undo the clear.
   assign st_in  = {pll_locked_in, osc_qualified_in};
   assign st_clr = {wr_pll, wr_pll || full_stop_entry};
   for (genvar i = 0; i < 2; i++) begin : g_st
      always_ff @(posedge sys_clk or negedge rstn) begin
         if (!rstn) begin
            st_prev_q[i] <= 1'b0;
            st_q[i]      <= 1'b0;
         end else begin
            st_prev_q[i] <= st_in[i];
            if (st_clr[i] || !st_in[i]) begin
               st_q[i] <= 1'b0;
            end else if (!st_prev_q[i]) begin
               st_q[i] <= 1'b1;
            end
         end
      end
   end

   // Status clear strobes to the analogue monitors
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         pll_status_clear <= 1'b0;
         osc_status_clear <= 1'b0;
      end else begin
         pll_status_clear <= st_clr[1];
         osc_status_clear <= st_clr[0];
      end
   end

   // Status outputs and the unlocked divide-by-4 select
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         osc_qualified <= 1'b0;
         pll_locked    <= 1'b0;
         pll_div4      <= 1'b1;
      end else begin
         osc_qualified <= st_q[0];
         pll_locked    <= st_q[1];
         pll_div4      <= !st_q[1];
      end
   end

   // Timer freeze in stop; counters are held, never reset
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         timer_freeze <= '0;
      end else begin
         timer_freeze.tick_freeze <= stop_active
            && !(clks_q.pseudo_stop_select && clks_q.tick_run_in_stop
                 && clks_q.tick_clock_source);
         timer_freeze.watchdog_freeze <= stop_active
            && !(clks_q.pseudo_stop_select && clks_q.watchdog_run_in_stop
                 && clks_q.watchdog_clock_source);
      end
   end

   // Restart pulses on any change of a timer source, by write or by loss
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         tick_restart     <= 1'b0;
         watchdog_restart <= 1'b0;
      end else begin
         tick_restart     <= clks_d.tick_clock_source
                             != clks_q.tick_clock_source;
         watchdog_restart <= clks_d.watchdog_clock_source
                             != clks_q.watchdog_clock_source;
      end
   end

   // Modulation step divider; the system clock stands in for the reference
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         fm_cnt_q      <= 8'h00;
         freq_mod_step <= 1'b0;
      end else if (fm_q == CCU_FM_OFF) begin
         fm_cnt_q      <= 8'h00;
         freq_mod_step <= 1'b0;
      end else begin
         fm_cnt_q      <= (fm_cnt_q == FM_LAST) ? 8'h00 : fm_cnt_q + 8'h01;
         freq_mod_step <= fm_cnt_q == FM_LAST;
      end
   end

   // Cycles since the last modulation step, kept only for the spacing
   // checks: a repetition count cannot follow the divider parameter
   logic [8:0] step_gap_q;
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         step_gap_q <= 9'h000;
      end else if (fm_q == CCU_FM_OFF) begin
         step_gap_q <= 9'h000;
      end else if (freq_mod_step) begin
         step_gap_q <= 9'h001;
      end else if (step_gap_q != 9'h1FF) begin
         step_gap_q <= step_gap_q + 9'h001;
      end
   end

   // Amplitude decode in percent of VCO frequency
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         freq_mod_amp <= CCU_FM_OFF;
         freq_mod_pct <= 3'h0;
      end else begin
         freq_mod_amp <= fm_q;
         unique case (fm_q)
            CCU_FM_OFF: freq_mod_pct <= 3'h0;
            CCU_FM_1PC: freq_mod_pct <= 3'h1;
            CCU_FM_2PC: freq_mod_pct <= 3'h2;
            CCU_FM_4PC: freq_mod_pct <= 3'h4;
         endcase
      end
   end

   // Register copy on the output port
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         clock_source_select <= ccu_clks_t'(`CCU_CLKS_RESET);
      end else begin
         clock_source_select <= clks_d;
      end
   end

   // Read port: data stands only in the cycle after the strobe
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         reg_rdata <= 8'h00;
      end else if (reg_rd && reg_addr == `CCU_OFS_CLKS) begin
         reg_rdata <= clks_q;
      end else if (reg_rd && reg_addr == `CCU_OFS_PLL) begin
         reg_rdata <= {2'h0, fm_q, 4'h0};
      end else begin
         reg_rdata <= 8'h00;
      end
   end

   // Checks on the control behaviour
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rstn);

   sequence s_pll_write;
      reg_wr && reg_addr == `CCU_OFS_PLL && !write_protect_flag
      && clks_q.system_clock_from_pll;
   endsequence

   sequence s_status_cleared;
      !st_q[1] && !st_q[0] ##1 !osc_qualified && !pll_locked && pll_div4;
   endsequence

   a_write_protect_flag_blocks: assert property (
      reg_wr && write_protect_flag |=> $stable(clks_q) || !$past(st_q[0])
         || $past(full_stop_entry))
      else $error("clock select changed under protection");

   a_normal_masked: assert property (
      reg_wr && reg_addr == `CCU_OFS_CLKS && !write_protect_flag
      && !special_mode && st_q[0] && !full_stop_entry
      |=> clks_q.pseudo_stop_select == $past(reg_wdata[`CCU_BIT_PSTOP]))
      else $error("normal mode write of stop select lost");

   a_wd_locked: assert property (
      wd_locked_q && !wd_rearm_q && !special_mode && !clks_q.watchdog_clock_source
      |=> !clks_q.watchdog_clock_source)
      else $error("watchdog source set while locked");

   a_qual_loss_sel: assert property (
      !st_q[0] |=> clks_q.system_clock_from_pll && !clks_q.tick_clock_source
         && !clks_q.watchdog_clock_source)
      else $error("oscillator loss did not force selects");

   a_full_stop_sel: assert property (
      full_stop_entry |=> clks_q.system_clock_from_pll ##1 !st_q[0])
      else $error("full stop entry did not force PLL select");

   a_tick_freeze: assert property (
      stop_active && !clks_q.tick_clock_source |=> timer_freeze.tick_freeze)
      else $error("tick timer ran in stop from RC clock");

   a_wd_freeze: assert property (
      stop_active && !clks_q.watchdog_run_in_stop
      |=> timer_freeze.watchdog_freeze)
      else $error("watchdog ran in stop while disabled");

   a_tick_restart: assert property (
      $changed(clks_q.tick_clock_source) |-> tick_restart)
      else $error("tick source change without restart");

   a_src_gate: assert property (
      !st_q[0] |=> !clks_q.tick_clock_source && !clks_q.watchdog_clock_source)
      else $error("timer source set without qualification");

   a_pll_wr_gate: assert property (
      reg_wr && reg_addr == `CCU_OFS_PLL && !clks_q.system_clock_from_pll
      |=> $stable(fm_q))
      else $error("PLL register written while oscillator selected");

   a_pll_clear: assert property (
      s_pll_write |=> s_status_cleared)
      else $error("PLL write did not clear status");

   a_fm_step: assert property (
      freq_mod_step && fm_q != CCU_FM_OFF |-> step_gap_q == 9'(FM_RATE_DIV))
      else $error("modulation step spacing wrong");

   a_fm_step_due: assert property (
      fm_q != CCU_FM_OFF |-> step_gap_q <= 9'(FM_RATE_DIV))
      else $error("modulation step overdue");

   a_fm_pct: assert property (
      fm_q == CCU_FM_4PC |=> freq_mod_pct == 3'h4)
      else $error("modulation amplitude decode wrong");

   a_rsv_zero: assert property (
      reg_rd |=> reg_rdata[5:4] == 2'h0
         || $past(reg_addr) == `CCU_OFS_PLL)
      else $error("reserved clock select bits read nonzero");

endmodule : ccu_clock_ctrl

/* File: bench/tb.sv */
// Self-checking bench for the clock select and PLL modulation registers.
// Assumes ccu_pkg compiled first and the design's own assertions bound inside it.
`timescale 1ns/100ps
module tb;
   import ccu_pkg::*;
   localparam int FM_DIV = 16;
   logic        sys_clk, rstn, reg_wr, reg_rd, write_protect_flag, special_mode;
   logic        watchdog_ctrl_write, stop_entry, stop_active, osc_qualified_in, pll_locked_in;
   logic [7:0]  reg_addr, reg_wdata, reg_rdata;
   ccu_clks_t   clock_source_select;
   ccu_freeze_t timer_freeze;
   ccu_fm_t     freq_mod_amp;
   logic [2:0]  freq_mod_pct;
   logic        tick_restart, watchdog_restart, osc_qualified, pll_locked, pll_div4, freq_mod_step;
   logic        pll_status_clear, osc_status_clear;
   int          n_mismatch, compares, cyc, n_tick, n_wd, n_step, s0, n_pclr, n_oclr;
   logic [2:0]  pct_tab [4] = '{3'h0, 3'h1, 3'h2, 3'h4};

   ccu_clock_ctrl #(.FM_RATE_DIV(FM_DIV)) dut (
      .sys_clk(sys_clk), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .write_protect_flag(write_protect_flag), .special_mode(special_mode),
      .watchdog_ctrl_write(watchdog_ctrl_write), .stop_entry(stop_entry),
      .stop_active(stop_active), .osc_qualified_in(osc_qualified_in),
      .pll_locked_in(pll_locked_in), .clock_source_select(clock_source_select),
      .timer_freeze(timer_freeze), .tick_restart(tick_restart),
      .watchdog_restart(watchdog_restart), .osc_qualified(osc_qualified),
      .pll_locked(pll_locked), .pll_status_clear(pll_status_clear),
      .osc_status_clear(osc_status_clear),
      .pll_div4(pll_div4), .freq_mod_amp(freq_mod_amp), .freq_mod_pct(freq_mod_pct),
      .freq_mod_step(freq_mod_step));

   // 20 MHz clock
   always #25 sys_clk = ~sys_clk;

   // Pulse counters and a hang guard sized well above the test length
   always @(posedge sys_clk) begin
      cyc <= cyc + 1;
      if (tick_restart === 1'b1) n_tick <= n_tick + 1;
      if (watchdog_restart === 1'b1) n_wd <= n_wd + 1;
      if (freq_mod_step === 1'b1) n_step <= n_step + 1;
      if (pll_status_clear === 1'b1) n_pclr <= n_pclr + 1;
      if (osc_status_clear === 1'b1) n_oclr <= n_oclr + 1;
      if (cyc == 3000) begin
         n_mismatch++;
         give_verdict();
      end
   end

   task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
      compares++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("mismatch %s expected %h seen %h", name, exp, seen);
      end
   endtask : chk

   // One-cycle write strobe, launched just after a rising edge; the idle
   // edge after it keeps two back-to-back strobes from sharing a time step
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_wr    <= 1'b1;
      @(posedge sys_clk);
      reg_wr    <= 1'b0;
      @(posedge sys_clk);
   endtask : wr

   // Read data stand only in the cycle after the strobe, so sample mid-cycle
   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      reg_addr <= a;
      reg_rd   <= 1'b1;
      @(posedge sys_clk);
      reg_rd   <= 1'b0;
      @(negedge sys_clk);
      chk("reg_rdata", reg_rdata, exp);
      @(posedge sys_clk);
   endtask : rd

   // Status needs a fresh rising edge of the monitor; wait is bounded
   task automatic set_osc(input logic lvl);
      int i;
      i = 0;
      osc_qualified_in <= 1'b0;
      repeat (2) @(posedge sys_clk);
      osc_qualified_in <= lvl;
      @(negedge sys_clk);
      while (osc_qualified !== lvl && i < 20) begin
         @(negedge sys_clk);
         i++;
      end
      chk("osc_qualified", {7'h00, osc_qualified}, {7'h00, lvl});
      @(posedge sys_clk);
   endtask : set_osc

   task automatic stop_pulse();
      stop_entry  <= 1'b1;
      stop_active <= 1'b1;
      @(posedge sys_clk);
      stop_entry  <= 1'b0;
      repeat (3) @(posedge sys_clk);
      @(negedge sys_clk);
   endtask : stop_pulse

   task automatic done(input string name);
      $display("test %s finished", name);
   endtask : done

   task automatic give_verdict();
      $display("compares %0d n_mismatch %0d", compares, n_mismatch);
      if (n_mismatch == 0 && compares > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask : give_verdict

   initial begin
      sys_clk = 1'b0; rstn = 1'b0; reg_wr = 1'b0; reg_rd = 1'b0; reg_addr = 8'h00;
      reg_wdata = 8'h00; write_protect_flag = 1'b0; special_mode = 1'b0;
      watchdog_ctrl_write = 1'b0; stop_entry = 1'b0; stop_active = 1'b0;
      osc_qualified_in = 1'b0; pll_locked_in = 1'b0;
      n_mismatch = 0; compares = 0; cyc = 0; n_tick = 0; n_wd = 0; n_step = 0; n_pclr = 0; n_oclr = 0;
      repeat (10) @(posedge sys_clk);
      rstn <= 1'b1;
      @(posedge sys_clk);
      // Reset images, unused offset reads zero
      rd(8'h39, 8'h80);
      rd(8'h3A, 8'h00);
      rd(8'h3B, 8'h00);
      // Unqualified oscillator: select cannot leave PLL, sources stay internal
      wr(8'h39, 8'h0F);
      rd(8'h39, 8'h8C);
      done("unqualified");
      set_osc(1'b1);
      wr(8'h39, 8'h4F);
      rd(8'h39, 8'h4F);
      write_protect_flag <= 1'b1;
      wr(8'h39, 8'h80);
      rd(8'h39, 8'h4F);
      write_protect_flag <= 1'b0;
      // Oscillator selected, so modulation writes are dropped
      wr(8'h3A, 8'h30);
      rd(8'h3A, 8'h00);
      done("normal_writes");
      watchdog_ctrl_write <= 1'b1;
      @(posedge sys_clk);
      watchdog_ctrl_write <= 1'b0;
      wr(8'h39, 8'hCE);
      rd(8'h39, 8'hCF);
      special_mode <= 1'b1;
      wr(8'h39, 8'hCE);
      rd(8'h39, 8'hCE);
      // Set again so that the coming loss really clears the watchdog source
      wr(8'h39, 8'hCF);
      rd(8'h39, 8'hCF);
      special_mode <= 1'b0;
      set_osc(1'b0);
      rd(8'h39, 8'hCC);
      set_osc(1'b1);
      // Loss rearms the watchdog source for one set only
      wr(8'h39, 8'hCF);
      rd(8'h39, 8'hCF);
      wr(8'h39, 8'hCE);
      rd(8'h39, 8'hCF);
      done("watchdog_lock");
      pll_locked_in <= 1'b1;
      repeat (4) @(posedge sys_clk);
      for (int k = 0; k < 4; k++) begin
         wr(8'h3A, {2'b00, 2'(k), 4'hF});
         rd(8'h3A, {2'b00, 2'(k), 4'h0});
         chk("freq_mod_amp", {6'h00, freq_mod_amp}, {6'h00, 2'(k)});
         chk("freq_mod_pct", {5'h00, freq_mod_pct}, {5'h00, pct_tab[k]});
         chk("osc_qualified", {7'h00, osc_qualified}, 8'h00);
         chk("pll_locked", {7'h00, pll_locked}, 8'h00);
         chk("pll_div4", {7'h00, pll_div4}, 8'h01);
      end
      pll_locked_in <= 1'b0;
      repeat (2) @(posedge sys_clk);
      pll_locked_in <= 1'b1;
      repeat (4) @(posedge sys_clk);
      @(negedge sys_clk);
      chk("pll_div4", {7'h00, pll_div4}, 8'h00);
      s0 = n_step;
      repeat (4 * FM_DIV) @(posedge sys_clk);
      // Let the last edge's count settle so the window holds 64 edges
      @(negedge sys_clk);
      chk("freq_mod_step", 8'(n_step - s0), 8'h04);
      done("modulation");
      // Modulation off before the oscillator is qualified again
      wr(8'h3A, 8'h00);
      set_osc(1'b1);
      wr(8'h39, 8'h4A);
      rd(8'h39, 8'h4A);
      // Pseudo stop: tick keeps running on the oscillator, watchdog held
      stop_pulse();
      chk("timer_freeze", {6'h00, timer_freeze}, 8'h01);
      @(posedge sys_clk);
      stop_active <= 1'b0;
      wr(8'h39, 8'h0A);
      // Full stop drops qualification and returns the system clock to PLL
      stop_pulse();
      chk("osc_qualified", {7'h00, osc_qualified}, 8'h00);
      chk("timer_freeze", {6'h00, timer_freeze}, 8'h03);
      @(posedge sys_clk);
      stop_active <= 1'b0;
      rd(8'h39, 8'h88);
      chk("clock_source_select", clock_source_select, 8'h88);
      chk("tick_restart count", 8'(n_tick), 8'h06);
      chk("watchdog_restart count", 8'(n_wd), 8'h06);
      chk("pll_status_clear count", 8'(n_pclr), 8'h05);
      chk("osc_status_clear count", 8'(n_oclr), 8'h06);
      done("stop_modes");
      give_verdict();
   end
endmodule : tb
